//--- cpcsr_regs.sv
// The Wishbone slave port is this design's own decision.
`timescale 1ns/10ps
// Contract
// - forced link good reports link permanently up
// - forcing ignored at gigabit speed
// - energy field: off, receive sense, sense plus pulses
// - crossover field: straight, crossed, reserved, automatic
// - crossover change applies only at software reset
// - transmitter disable stops copper transmitter
// - leave power down only when both bits zero
// - power down exit forces reset and restart
// - polarity disable forces normal in ten megabit
// - jabber disable matters only ten half duplex
// - speed codes, reset value two
// - speed and duplex valid only when resolved
// - resolved set on completion or negotiation off
// - duplex bit one means full duplex
// - page received latches high
// - latched bit clears on read unless present
// - update fields apply on reset, restart, wake, loss
module cpcsr_regs
  import cpcsr_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic link_raw_i,
  input wire logic [1:0] line_speed_i,
  input wire logic line_duplex_i,
  input wire logic an_complete_i,
  input wire logic page_arrived_i,
  output logic link_up_o,
  output logic tx_enable_o,
  output logic power_down_o,
  output logic sw_reset_o,
  output logic an_restart_o,
  output logic [1:0] crossed_wiring_mode_o,
  output logic energy_sense_en_o,
  output logic normal_link_pulse_periodic_o,
  output logic link_pulse_disable_o,
  output logic polarity_correct_en_o,
  output logic jabber_check_en_o,
  output logic irq_o
);

  function automatic logic hit(input logic [7:0] adr, input logic [5:0] idx);
    hit = (adr[7:2] == idx);
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] sel);
    merge16 = {sel[1] ? wd[15:8] : old[15:8], sel[0] ? wd[7:0] : old[7:0]};
  endfunction

  logic ack_reg;
  logic [31:0] dat_reg;
  logic [15:0] basic_reg;
  logic [15:0] ctrl_reg;
  logic [15:0] ctrl_act_reg;
  logic [1:0] xover_act_reg;
  logic [1:0] speed_reg;
  logic duplex_reg;
  logic page_reg;
  logic link_up_reg;
  logic pd_reg;
  logic sw_reset_reg;
  logic an_restart_reg;
  logic [IRQ_W-1:0] irq_stat_reg;
  logic [IRQ_W-1:0] irq_en_reg;
  logic resolved_prev_reg;
  logic req;
  logic acc;
  logic wr;
  logic rd_stat;
  logic resolved;
  logic power_down_next;
  logic pd_exit;
  logic sw_reset_next;
  logic an_restart_next;
  logic link_up_next;
  logic link_loss;
  logic upd_evt;
  logic [15:0] basic_wr;
  logic [15:0] stat_word;
  logic [IRQ_W-1:0] irq_evt;
  logic [IRQ_W-1:0] irq_clr;

  // bus slave: one wait state, action at the ack edge
  assign req = cyc_i && stb_i;
  assign acc = req && ack_reg;
  assign wr = acc && we_i;
  assign rd_stat = acc && !we_i && hit(adr_i, IDX_STAT);
  assign ack_o = ack_reg;
  assign dat_o = dat_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req && !ack_reg;
    end
  end

  // read data captured in the cycle before ack, unmapped reads zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_reg <= 32'h0000_0000;
    end else if (req && !ack_reg) begin
      dat_reg <= 32'h0000_0000;
      if (hit(adr_i, IDX_BASIC)) begin
        dat_reg[15:0] <= basic_reg;
      end else if (hit(adr_i, IDX_CTRL)) begin
        dat_reg[15:0] <= ctrl_reg;
      end else if (hit(adr_i, IDX_STAT)) begin
        dat_reg[15:0] <= stat_word;
      end else if (hit(adr_i, IDX_IRQ_STAT)) begin
        dat_reg[IRQ_W-1:0] <= irq_stat_reg;
      end else if (hit(adr_i, IDX_IRQ_EN)) begin
        dat_reg[IRQ_W-1:0] <= irq_en_reg;
      end
    end
  end

  // basic control: self-clearing reset and restart requests
  assign basic_wr = merge16(basic_reg, dat_i, sel_i);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      basic_reg <= BASIC_RESET;
    end else if (wr && hit(adr_i, IDX_BASIC)) begin
      basic_reg <= basic_wr & BASIC_STORE_MASK;
    end
  end

  // copper control word
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= CTRL_RESET;
    end else if (wr && hit(adr_i, IDX_CTRL)) begin
      ctrl_reg <= merge16(ctrl_reg, dat_i, sel_i);
      ctrl_reg[CTRL_NO_ACCESS] <= 1'b0;
    end else if (sw_reset_reg) begin
      ctrl_reg[CTRL_LINK_PULSE_DIS] <= 1'b0;
    end
  end

  // power down and automatic reset on wake
  assign power_down_next = ctrl_reg[CTRL_PD] || basic_reg[BASIC_PD];
  assign pd_exit = pd_reg && !power_down_next;
  assign sw_reset_next = (wr && hit(adr_i, IDX_BASIC) && sel_i[1] && dat_i[BASIC_SW_RESET]) || pd_exit;
  assign an_restart_next = (wr && hit(adr_i, IDX_BASIC) && sel_i[1] && dat_i[BASIC_AN_RESTART]) || pd_exit;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pd_reg <= 1'b0;
      sw_reset_reg <= 1'b0;
      an_restart_reg <= 1'b0;
    end else begin
      pd_reg <= power_down_next;
      sw_reset_reg <= sw_reset_next;
      an_restart_reg <= an_restart_next;
    end
  end

  // link report with forced good outside gigabit
  assign link_up_next = link_raw_i || (ctrl_reg[CTRL_FORCE_LINK] && line_speed_i != SPEED_1000);
  assign link_loss = link_up_reg && !link_up_next;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      link_up_reg <= 1'b0;
    end else begin
      link_up_reg <= link_up_next;
    end
  end

  // deferred fields take effect only on their update events
  assign upd_evt = sw_reset_reg || an_restart_reg || pd_exit || link_loss;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_act_reg <= CTRL_RESET & CTRL_UPDATE_MASK;
    end else if (upd_evt) begin
      ctrl_act_reg <= ctrl_reg & CTRL_UPDATE_MASK;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      xover_act_reg <= XOVER_AUTO;
    end else if (sw_reset_reg) begin
      xover_act_reg <= ctrl_reg[CTRL_XOVER_HI:CTRL_XOVER_LO];
    end
  end

  // resolution and status capture
  assign resolved = an_complete_i || !basic_reg[BASIC_AN_EN];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      speed_reg <= SPEED_RESET;
      duplex_reg <= 1'b0;
    end else if (resolved) begin
      speed_reg <= line_speed_i;
      duplex_reg <= line_duplex_i;
    end
  end

  // latched page flag, set wins over clear on read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      page_reg <= 1'b0;
    end else if (page_arrived_i) begin
      page_reg <= 1'b1;
    end else if (rd_stat) begin
      page_reg <= 1'b0;
    end
  end

  assign stat_word = {speed_reg, duplex_reg, page_reg, resolved, 11'h000};

  // interrupts: sticky status, write one to clear, enable mask
  assign irq_evt[IRQ_PAGE] = page_arrived_i;
  assign irq_evt[IRQ_RESOLVED] = resolved && !resolved_prev_reg;
  assign irq_evt[IRQ_LINK] = link_up_reg != link_up_next;
  assign irq_clr = (wr && hit(adr_i, IDX_IRQ_CLR) && sel_i[0]) ? dat_i[IRQ_W-1:0] : '0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      resolved_prev_reg <= 1'b0;
    end else begin
      resolved_prev_reg <= resolved;
    end
  end

  generate
    for (genvar g = 0; g < IRQ_W; g++) begin : g_irq
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          irq_stat_reg[g] <= 1'b0;
        end else if (irq_evt[g]) begin
          irq_stat_reg[g] <= 1'b1;
        end else if (irq_clr[g]) begin
          irq_stat_reg[g] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_en_reg <= '0;
    end else if (wr && hit(adr_i, IDX_IRQ_EN) && sel_i[0]) begin
      irq_en_reg <= dat_i[IRQ_W-1:0];
    end
  end

  assign irq_o = |(irq_stat_reg & irq_en_reg);

  // line-side controls
  assign link_up_o = link_up_reg;
  assign tx_enable_o = !ctrl_reg[CTRL_TX_DIS];
  assign power_down_o = pd_reg;
  assign sw_reset_o = sw_reset_reg;
  assign an_restart_o = an_restart_reg;
  assign crossed_wiring_mode_o = xover_act_reg;
  assign energy_sense_en_o = ctrl_act_reg[CTRL_ENERGY_HI];
  assign normal_link_pulse_periodic_o = ctrl_act_reg[CTRL_ENERGY_HI] && ctrl_act_reg[CTRL_ENERGY_LO];
  assign link_pulse_disable_o = ctrl_reg[CTRL_LINK_PULSE_DIS];
  assign polarity_correct_en_o = !(ctrl_reg[CTRL_POL_DIS] && line_speed_i == SPEED_10);
  assign jabber_check_en_o = !ctrl_reg[CTRL_JAB_DIS] && line_speed_i == SPEED_10 && !line_duplex_i;

  // checks
  chk_force_link_up: assert property (@(posedge clk_i) disable iff (rst_i)
    ctrl_reg[CTRL_FORCE_LINK] && line_speed_i != SPEED_1000 |=> link_up_o)
    else $error("forced link not reported up");

  chk_force_gig_ignored: assert property (@(posedge clk_i) disable iff (rst_i)
    !link_raw_i && line_speed_i == SPEED_1000 |=> !link_up_o)
    else $error("forced link acted at gigabit");

  chk_energy_decode: assert property (@(posedge clk_i) disable iff (rst_i)
    upd_evt |=> energy_sense_en_o == $past(ctrl_reg[CTRL_ENERGY_HI]) &&
      normal_link_pulse_periodic_o == $past(ctrl_reg[CTRL_ENERGY_HI] && ctrl_reg[CTRL_ENERGY_LO]))
    else $error("energy sense decode wrong");

  chk_xover_deferred: assert property (@(posedge clk_i) disable iff (rst_i)
    !sw_reset_reg |=> $stable(crossed_wiring_mode_o))
    else $error("crossover moved without software reset");

  chk_xover_load: assert property (@(posedge clk_i) disable iff (rst_i)
    sw_reset_reg |=> crossed_wiring_mode_o == $past(ctrl_reg[CTRL_XOVER_HI:CTRL_XOVER_LO]))
    else $error("crossover not loaded at reset");

  chk_tx_disable: assert property (@(posedge clk_i) disable iff (rst_i)
    ctrl_reg[CTRL_TX_DIS] |-> !tx_enable_o)
    else $error("transmitter driven while disabled");

  chk_pd_both_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(power_down_o) |-> $past(!ctrl_reg[CTRL_PD] && !basic_reg[BASIC_PD]))
    else $error("left power down with a bit set");

  chk_wake_reset: assert property (@(posedge clk_i) disable iff (rst_i)
    power_down_o && !power_down_next |=> sw_reset_o && an_restart_o)
    else $error("no reset and restart on wake");

  chk_polarity_normal: assert property (@(posedge clk_i) disable iff (rst_i)
    ctrl_reg[CTRL_POL_DIS] && line_speed_i == SPEED_10 |-> !polarity_correct_en_o)
    else $error("polarity correction while disabled");

  chk_jabber_scope: assert property (@(posedge clk_i) disable iff (rst_i)
    jabber_check_en_o |-> line_speed_i == SPEED_10 && !line_duplex_i)
    else $error("jabber active outside ten half duplex");

  chk_speed_capture: assert property (@(posedge clk_i) disable iff (rst_i)
    resolved |=> speed_reg == $past(line_speed_i) && duplex_reg == $past(line_duplex_i))
    else $error("speed or duplex not captured");

  chk_resolved_an_off: assert property (@(posedge clk_i) disable iff (rst_i)
    !basic_reg[BASIC_AN_EN] |-> stat_word[STAT_RESOLVED])
    else $error("resolved low with negotiation off");

  chk_page_latch: assert property (@(posedge clk_i) disable iff (rst_i)
    page_arrived_i |=> page_reg [*2] or (page_reg ##1 $past(rd_stat)))
    else $error("page flag not latched");

  chk_page_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_stat && !page_arrived_i |=> !page_reg)
    else $error("page flag not cleared on read");

  chk_update_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !upd_evt |=> $stable(ctrl_act_reg))
    else $error("deferred field changed without event");

  chk_no_access_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    !ctrl_reg[CTRL_NO_ACCESS])
    else $error("no-access bit read nonzero");

  chk_ack_one_wait: assert property (@(posedge clk_i) disable iff (rst_i)
    req && !ack_o |=> ack_o ##1 !ack_o)
    else $error("ack timing wrong");

  chk_resolved_complete: assert property (@(posedge clk_i) disable iff (rst_i)
    an_complete_i |-> stat_word[STAT_RESOLVED])
    else $error("resolved low after negotiation complete");

  chk_link_loss_load: assert property (@(posedge clk_i) disable iff (rst_i)
    link_loss |=> ctrl_act_reg == $past(ctrl_reg & CTRL_UPDATE_MASK))
    else $error("deferred fields not loaded on link loss");

  chk_pulse_dis_reset: assert property (@(posedge clk_i) disable iff (rst_i)
    sw_reset_reg && !(wr && hit(adr_i, IDX_CTRL)) |=> !link_pulse_disable_o)
    else $error("link pulse disable kept over software reset");

  chk_irq_set: assert property (@(posedge clk_i) disable iff (rst_i)
    irq_evt[IRQ_PAGE] |=> irq_stat_reg[IRQ_PAGE])
    else $error("page interrupt status not set");

  chk_irq_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    irq_clr[IRQ_PAGE] && !irq_evt[IRQ_PAGE] |=> !irq_stat_reg[IRQ_PAGE])
    else $error("page interrupt status not cleared");

  cov_wake: cover property (@(posedge clk_i) disable iff (rst_i) power_down_o ##1 !power_down_o);
  cov_page_read: cover property (@(posedge clk_i) disable iff (rst_i) page_reg ##1 rd_stat ##1 !page_reg);
  cov_force_link: cover property (@(posedge clk_i) disable iff (rst_i) !link_raw_i && link_up_o);
  cov_irq: cover property (@(posedge clk_i) disable iff (rst_i) irq_o);
  cov_xover_load: cover property (@(posedge clk_i) disable iff (rst_i) sw_reset_reg ##1 crossed_wiring_mode_o == XOVER_CROSSED);

endmodule // cpcsr_regs

//--- cpcsr_pkg.sv
package cpcsr_pkg;
  // word indices, byte address is four times the index
  localparam logic [5:0] IDX_BASIC = 6'h00;
  localparam logic [5:0] IDX_CTRL = 6'h10;
  localparam logic [5:0] IDX_STAT = 6'h11;
  localparam logic [5:0] IDX_IRQ_STAT = 6'h14;
  localparam logic [5:0] IDX_IRQ_CLR = 6'h15;
  localparam logic [5:0] IDX_IRQ_EN = 6'h16;
  // basic control fields
  localparam int BASIC_SW_RESET = 15;
  localparam int BASIC_AN_EN = 12;
  localparam int BASIC_PD = 11;
  localparam int BASIC_AN_RESTART = 9;
  localparam logic [15:0] BASIC_RESET = 16'h1000;
  localparam logic [15:0] BASIC_STORE_MASK = 16'h1800;
  // copper control fields
  localparam int CTRL_LINK_PULSE_DIS = 15;
  localparam int CTRL_FORCE_LINK = 10;
  localparam int CTRL_ENERGY_HI = 9;
  localparam int CTRL_ENERGY_LO = 8;
  localparam int CTRL_NO_ACCESS = 7;
  localparam int CTRL_XOVER_HI = 6;
  localparam int CTRL_XOVER_LO = 5;
  localparam int CTRL_TX_DIS = 3;
  localparam int CTRL_PD = 2;
  localparam int CTRL_POL_DIS = 1;
  localparam int CTRL_JAB_DIS = 0;
  localparam logic [15:0] CTRL_RESET = 16'h3060;
  localparam logic [15:0] CTRL_UPDATE_MASK = 16'h7b00;
  // copper status fields
  localparam int STAT_SPEED_HI = 15;
  localparam int STAT_SPEED_LO = 14;
  localparam int STAT_DUPLEX = 13;
  localparam int STAT_PAGE = 12;
  localparam int STAT_RESOLVED = 11;
  localparam logic [1:0] SPEED_RESET = 2'h2;
  localparam logic [1:0] SPEED_1000 = 2'h2;
  localparam logic [1:0] SPEED_100 = 2'h1;
  localparam logic [1:0] SPEED_10 = 2'h0;
  localparam logic [1:0] XOVER_STRAIGHT = 2'h0;
  localparam logic [1:0] XOVER_CROSSED = 2'h1;
  localparam logic [1:0] XOVER_AUTO = 2'h3;
  // interrupt bits
  localparam int IRQ_W = 3;
  localparam int IRQ_PAGE = 0;
  localparam int IRQ_RESOLVED = 1;
  localparam int IRQ_LINK = 2;
endpackage

//--- cpcsr_host_model.sv
`timescale 1ns/10ps
module cpcsr_host_model
  import cpcsr_pkg::*;
(
  input wire logic clk_i,
  input wire logic ack_i,
  input wire logic [31:0] dat_i,
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [7:0] adr_o,
  output logic [3:0] sel_o,
  output logic [31:0] dat_o
);
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o = 1'b0;
    adr_o = 8'h00;
    sel_o = 4'h0;
    dat_o = 32'h0;
  end
  // reserved control bits kept at their reset value
  function automatic logic [15:0] ctrl_word(input logic [15:0] f);
    return (f & ~16'h7810) | 16'h3000;
  endfunction
  // one classic cycle; on release, address and data lines show inverted values
  // upper data half carries junk that the slave must ignore
  task automatic access(input logic w, input logic [5:0] idx, input logic [15:0] wd, input logic [3:0] be,
                        output logic [15:0] rd);
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= w;
    adr_o <= {idx, 2'h0};
    sel_o <= be;
    dat_o <= {~wd, wd};
    do @(posedge clk_i); while (ack_i !== 1'b1);
    rd = dat_i[15:0];
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    adr_o <= ~adr_o;
    dat_o <= ~dat_o;
  endtask
endmodule // cpcsr_host_model

//--- copper_phy_control_status_regs_tb_top.sv
`timescale 1ns/10ps
module copper_phy_control_status_regs_tb_top;
  import cpcsr_pkg::*;
  logic clk, rst, cyc, stb, we, ack, lnk, dup, anc, pg;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] dw, dr;
  logic [1:0] spd, xw;
  logic lu, txe, pd, swr, anr, es, normal_link_pulse, lpd, pol, jab, irq;
  logic [15:0] rd;
  int error_cnt = 0;
  int samples_checked = 0;
  int sw_cnt = 0;
  int an_cnt = 0;
  cpcsr_host_model host (.clk_i(clk), .ack_i(ack), .dat_i(dr), .cyc_o(cyc), .stb_o(stb), .we_o(we),
    .adr_o(adr), .sel_o(sel), .dat_o(dw));
  cpcsr_regs uut (.clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
    .dat_i(dw), .dat_o(dr), .ack_o(ack), .link_raw_i(lnk), .line_speed_i(spd), .line_duplex_i(dup),
    .an_complete_i(anc), .page_arrived_i(pg), .link_up_o(lu), .tx_enable_o(txe), .power_down_o(pd),
    .sw_reset_o(swr), .an_restart_o(anr), .crossed_wiring_mode_o(xw), .energy_sense_en_o(es),
    .normal_link_pulse_periodic_o(normal_link_pulse), .link_pulse_disable_o(lpd), .polarity_correct_en_o(pol),
    .jabber_check_en_o(jab), .irq_o(irq));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    if (swr === 1'b1) sw_cnt++;
    if (anr === 1'b1) an_cnt++;
  end
  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [5:0] idx, input logic [15:0] d);
    host.access(1'b1, idx, d, 4'h3, rd);
  endtask
  task automatic rdr(input logic [5:0] idx);
    host.access(1'b0, idx, 16'h0, 4'h3, rd);
  endtask
  task automatic line(input logic l, input logic [1:0] s, input logic d, input logic a);
    @(posedge clk);
    lnk <= l;
    spd <= s;
    dup <= d;
    anc <= a;
    repeat (3) @(posedge clk);
  endtask
  task automatic pulse_page;
    @(posedge clk);
    pg <= 1'b1;
    @(posedge clk);
    pg <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic t_reset;
    rdr(IDX_CTRL);
    chk("ctrl reset", CTRL_RESET, rd);
    chk("xover reset", {14'h0, XOVER_AUTO}, {14'h0, xw});
    rdr(IDX_STAT);
    chk("status reset", {SPEED_RESET, 14'h0}, rd);
    rdr(6'h3f);
    chk("unmapped read", 16'h0, rd);
    chk("tx reset", 16'h1, {15'h0, txe});
    chk("link pulse reset", 16'h0, {15'h0, lpd});
    wr(IDX_CTRL, host.ctrl_word(16'h8060));
    repeat (2) @(posedge clk);
    chk("link pulse set", 16'h1, {15'h0, lpd});
    wr(IDX_BASIC, 16'h9000);
    repeat (3) @(posedge clk);
    chk("link pulse sw reset", 16'h0, {15'h0, lpd});
    host.access(1'b1, IDX_CTRL, 16'hff08, 4'h1, rd);
    rdr(IDX_CTRL);
    chk("byte lane write", 16'h3008, rd);
    chk("tx lane disabled", 16'h0, {15'h0, txe});
    wr(IDX_CTRL, host.ctrl_word(16'h0060));
  endtask
  task automatic t_xover;
    logic [1:0] xv[3] = '{XOVER_STRAIGHT, XOVER_CROSSED, XOVER_AUTO};
    logic [1:0] en[3] = '{2'h2, 2'h3, 2'h0};
    logic [1:0] px, pe;
    px = XOVER_AUTO;
    pe = 2'h0;
    for (int i = 0; i < 3; i++) begin
      wr(IDX_CTRL, host.ctrl_word({6'h0, en[i], 1'b1, xv[i], 5'h0}));
      repeat (3) @(posedge clk);
      chk("xover held", {14'h0, px}, {14'h0, xw});
      chk("energy held", {14'h0, pe[1], &pe}, {14'h0, es, normal_link_pulse});
      rdr(IDX_CTRL);
      chk("ctrl readback", host.ctrl_word({6'h0, en[i], 1'b0, xv[i], 5'h0}), rd);
      wr(IDX_BASIC, 16'h9000);
      repeat (3) @(posedge clk);
      chk("xover active", {14'h0, xv[i]}, {14'h0, xw});
      chk("energy active", {14'h0, en[i][1], &en[i]}, {14'h0, es, normal_link_pulse});
      px = xv[i];
      pe = en[i];
    end
  endtask
  task automatic t_force_tx;
    line(1'b0, SPEED_100, 1'b0, 1'b0);
    wr(IDX_CTRL, host.ctrl_word(16'h0460));
    repeat (2) @(posedge clk);
    chk("forced link", 16'h1, {15'h0, lu});
    line(1'b0, SPEED_1000, 1'b0, 1'b0);
    chk("forced link gigabit", 16'h0, {15'h0, lu});
    wr(IDX_CTRL, host.ctrl_word(16'h0068));
    line(1'b0, SPEED_100, 1'b0, 1'b0);
    chk("link normal", 16'h0, {15'h0, lu});
    chk("tx disabled", 16'h0, {15'h0, txe});
    wr(IDX_CTRL, host.ctrl_word(16'h0060));
    repeat (2) @(posedge clk);
    chk("tx enabled", 16'h1, {15'h0, txe});
  endtask
  task automatic t_power;
    int s, a;
    wr(IDX_CTRL, host.ctrl_word(16'h0064));
    wr(IDX_BASIC, 16'h1800);
    wr(IDX_CTRL, host.ctrl_word(16'h0060));
    repeat (2) @(posedge clk);
    chk("power down held", 16'h1, {15'h0, pd});
    s = sw_cnt;
    a = an_cnt;
    wr(IDX_BASIC, 16'h1000);
    repeat (4) @(posedge clk);
    chk("power down exit", 16'h0, {15'h0, pd});
    chk("reset on wake", 16'h1, 16'(sw_cnt - s));
    chk("restart on wake", 16'h1, 16'(an_cnt - a));
  endtask
  task automatic t_pol_jab;
    line(1'b1, SPEED_10, 1'b0, 1'b0);
    wr(IDX_CTRL, host.ctrl_word(16'h0062));
    repeat (2) @(posedge clk);
    chk("polarity ten", 16'h0, {15'h0, pol});
    line(1'b1, SPEED_100, 1'b0, 1'b0);
    chk("polarity hundred", 16'h1, {15'h0, pol});
    wr(IDX_CTRL, host.ctrl_word(16'h0060));
    line(1'b1, SPEED_10, 1'b0, 1'b0);
    chk("jabber ten half", 16'h1, {15'h0, jab});
    line(1'b1, SPEED_10, 1'b1, 1'b0);
    chk("jabber ten full", 16'h0, {15'h0, jab});
    line(1'b1, SPEED_10, 1'b0, 1'b0);
    wr(IDX_CTRL, host.ctrl_word(16'h0061));
    repeat (2) @(posedge clk);
    chk("jabber disabled", 16'h0, {15'h0, jab});
  endtask
  task automatic t_status;
    line(1'b1, SPEED_100, 1'b1, 1'b1);
    rdr(IDX_STAT);
    chk("status resolved", 16'h6800, rd);
    line(1'b1, SPEED_10, 1'b0, 1'b0);
    rdr(IDX_STAT);
    chk("status unresolved", 16'h0, {15'h0, rd[STAT_RESOLVED]});
    wr(IDX_BASIC, 16'h0000);
    repeat (2) @(posedge clk);
    rdr(IDX_STAT);
    chk("status an off", 16'h0800, rd);
    wr(IDX_BASIC, 16'h1000);
  endtask
  task automatic t_page_irq;
    wr(IDX_IRQ_CLR, 16'h0007);
    wr(IDX_IRQ_EN, 16'h0001);
    repeat (2) @(posedge clk);
    chk("irq idle", 16'h0, {15'h0, irq});
    pulse_page();
    chk("irq raised", 16'h1, {15'h0, irq});
    rdr(IDX_STAT);
    chk("page latched", 16'h1, {15'h0, rd[STAT_PAGE]});
    rdr(IDX_STAT);
    chk("page cleared", 16'h0, {15'h0, rd[STAT_PAGE]});
    wr(IDX_IRQ_CLR, 16'h0001);
    repeat (2) @(posedge clk);
    chk("irq cleared", 16'h0, {15'h0, irq});
    wr(IDX_IRQ_EN, 16'h0000);
    pulse_page();
    chk("irq masked", 16'h0, {15'h0, irq});
    rdr(IDX_IRQ_STAT);
    chk("irq status sticky", 16'h1, {15'h0, rd[IRQ_PAGE]});
    line(1'b0, SPEED_10, 1'b0, 1'b1);
    rdr(IDX_IRQ_STAT);
    chk("irq status events", 16'h7, rd);
    wr(IDX_IRQ_EN, 16'h0006);
    repeat (2) @(posedge clk);
    chk("irq link resolved", 16'h1, {15'h0, irq});
  endtask
  initial begin
    rst = 1'b1;
    lnk = 1'b0;
    spd = SPEED_1000;
    dup = 1'b0;
    anc = 1'b0;
    pg = 1'b0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_xover();
    t_force_tx();
    t_power();
    t_pol_jab();
    t_status();
    t_page_irq();
    finish_test();
  end
  initial begin
    #100000;
    error_cnt++;
    finish_test();
  end
endmodule // copper_phy_control_status_regs_tb_top
